// ### design/lcs_setup_status.sv
`include "lcs_consts.svh"
`default_nettype none
// How it works
// - setup block is seven 32-bit words, taken whole, one copy per channel
// - any bad word drops the whole block, flags error with a reason code
// - gradient accepted 80000..99999, default 90000
// - length 2..800 in or 50..20320 mm; count 2..1000*len or 10*len
// - config bits 7:0 and 31:17 must be zero, read back as zero
// - config bit 8 picks self-clearing or latched faults
// - config bit 9 makes scaled position count negative
// - config bit 10 picks 160ms or 60ms velocity period
// - config bits 11/12 capture position on latch rise/fall
// - config bit 13 picks units, 0 inches 1 mm as written
// - config bits 16:14 pick transducer mode, codes 4..7 rejected
// - accepting a new block zeroes the preset offset; a preset edge in the same cycle wins
// - after reset run from stored setup or factory defaults
// - setup read returns seven stored words plus preset offset
// - image per channel: status, position, velocity, captured, interpolated
// - status 0 echoes preset command, status 1 echoes interp after done
// - status 2 no motion late in period, status 3 falling direction
// - status 4 shows live latch input
// - status 5/6 window test of position and interpolated position
// - status 7 transducer fault, latched until clear command if set
// - status 14 set while command bits 31:3 nonzero
// - status 15 stored parameter checksum failed, defaults used
// - codes 1 config, 2 gradient, 3 length, 4 count, 10 channel two
module lcs_setup_status
  import lcs_pkg::*;
#(
  parameter int unsigned VEL_SLOW_CYC = `LCS_VEL_SLOW_MS * `LCS_CLK_KHZ,
  parameter int unsigned VEL_FAST_CYC = `LCS_VEL_FAST_MS * `LCS_CLK_KHZ
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // rack configuration
  input wire logic two_chan,
  // setup write
  input wire logic wr_valid,
  input wire logic wr_chan,
  input wire lcs_setup_t wr_block,
  output logic wr_done,
  output logic wr_err,
  output logic [7:0] wr_code,
  // setup read
  input wire logic rd_req,
  input wire logic rd_chan,
  input wire logic [2:0] rd_idx,
  output logic rd_valid,
  output lcs_word_t rd_data,
  // stored setup from non-volatile memory
  input wire logic [1:0] nv_present,
  input wire logic [1:0] nv_crc_ok,
  input wire lcs_setup_t [1:0] nv_block,
  // host command words
  input wire lcs_word_t [1:0] cmd_word,
  // scaling and velocity arithmetic
  input wire lcs_word_t [1:0] raw_pos,
  input wire lcs_word_t [1:0] raw_vel,
  input wire logic [1:0] interp_done,
  input wire lcs_word_t [1:0] interp_pos,
  output logic [1:0] interp_req,
  output lcs_setup_t [1:0] active_setup,
  // transducer pins
  input wire logic [1:0] latch_pin,
  input wire logic [1:0] fault_pin,
  // input image
  output lcs_word_t [9:0] image
);

  lcs_state_t s_q;
  lcs_state_t s_d;

  // reason code for a received block, zero when good
  function automatic logic [7:0] check_block(input lcs_setup_t b, input logic ch, input logic two);
    logic mm;
    logic [41:0] cmax;
    mm = b[`LCS_W_CFG][`LCS_CFG_MM];
    cmax = mm ? 42'(b[`LCS_W_LEN]) * 42'(`LCS_CNT_MM_MUL) : 42'(b[`LCS_W_LEN]) * 42'(`LCS_CNT_IN_MUL);
    if (ch && !two) begin
      check_block = `LCS_ERR_CH2;
    end else if ((b[`LCS_W_CFG] & ~`LCS_CFG_VALID_MASK) != 32'h00000000 ||
                 b[`LCS_W_CFG][16:14] > `LCS_MODE_MAX) begin
      check_block = `LCS_ERR_CFG;
    end else if (b[`LCS_W_GRAD] < `LCS_GRAD_MIN || b[`LCS_W_GRAD] > `LCS_GRAD_MAX) begin
      check_block = `LCS_ERR_GRAD;
    end else if (mm ? (b[`LCS_W_LEN] < `LCS_LEN_MM_MIN || b[`LCS_W_LEN] > `LCS_LEN_MM_MAX)
                    : (b[`LCS_W_LEN] < `LCS_LEN_IN_MIN || b[`LCS_W_LEN] > `LCS_LEN_IN_MAX)) begin
      check_block = `LCS_ERR_LEN;
    end else if (b[`LCS_W_CNT] < `LCS_CNT_MIN || 42'(b[`LCS_W_CNT]) > cmax) begin
      check_block = `LCS_ERR_CNT;
    end else begin
      check_block = `LCS_ERR_NONE;
    end
  endfunction : check_block

  // signed window, inclusive at both setpoints
  function automatic logic in_window(input lcs_word_t x, input lcs_word_t on, input lcs_word_t off);
    in_window = $signed(on) <= $signed(x) && $signed(x) <= $signed(off);
  endfunction : in_window

  // next state
  always_comb begin
    logic [7:0] code;
    lcs_word_t base;
    lcs_word_t pos_n;
    logic [31:0] per_len;
    logic [31:0] late_start;
    logic lat;
    logic flt;
    logic [2:0] cmd;
    logic [2:0] cmd_rise;
    logic cfl;
    code = `LCS_ERR_NONE;
    base = 32'h00000000;
    pos_n = 32'h00000000;
    per_len = 32'h00000000;
    late_start = 32'h00000000;
    lat = 1'b0;
    flt = 1'b0;
    cmd = 3'h0;
    cmd_rise = 3'h0;
    cfl = 1'b0;
    s_d = s_q;
    s_d.wr_done = 1'b0;
    s_d.rd_valid = 1'b0;
    s_d.booted = 1'b1;

    // setup write, answered next cycle
    if (wr_valid) begin
      code = check_block(wr_block, wr_chan, two_chan);
      s_d.wr_done = 1'b1;
      s_d.wr_err = code != `LCS_ERR_NONE;
      s_d.wr_code = code;
    end

    for (int c = 0; c < 2; c++) begin
      // stored setup replaces defaults once after reset
      if (!s_q.booted) begin
        if (nv_present[c] && nv_crc_ok[c]) begin
          s_d.ch[c].setup = nv_block[c];
        end
        s_d.ch[c].crc_bad = nv_present[c] && !nv_crc_ok[c];
      end

      // whole block or nothing
      if (wr_valid && wr_chan == 1'(c) && code == `LCS_ERR_NONE) begin
        s_d.ch[c].setup = wr_block;
        s_d.ch[c].offset = 32'h00000000;
      end

      // pin inputs pass two flops first
      s_d.ch[c].lat_s = {s_q.ch[c].lat_s[0], latch_pin[c]};
      s_d.ch[c].flt_s = {s_q.ch[c].flt_s[0], fault_pin[c]};
      lat = s_q.ch[c].lat_s[1];
      flt = s_q.ch[c].flt_s[1];
      s_d.ch[c].lat_prev = lat;

      cmd = cmd_word[c][2:0];
      cmd_rise = cmd & ~s_q.ch[c].cmd_prev;
      s_d.ch[c].cmd_prev = cmd;
      s_d.ch[c].cmd_bad = cmd_word[c][31:3] != 29'h00000000;

      // direction applied before the preset offset
      base = s_q.ch[c].setup[`LCS_W_CFG][`LCS_CFG_DIR_NEG] ? 32'(-raw_pos[c]) : raw_pos[c];
      if (cmd_rise[`LCS_CMD_PRESET]) begin
        s_d.ch[c].offset = 32'(s_q.ch[c].setup[`LCS_W_PRESET] - base);
      end
      pos_n = 32'(base + s_d.ch[c].offset);
      s_d.ch[c].pos = pos_n;
      s_d.ch[c].vel = raw_vel[c];
      s_d.ch[c].ack_pre = cmd[`LCS_CMD_PRESET];

      // direction holds when the position stands still
      if ($signed(pos_n) < $signed(s_q.ch[c].pos)) begin
        s_d.ch[c].dir_dn = 1'b1;
      end else if ($signed(pos_n) > $signed(s_q.ch[c].pos)) begin
        s_d.ch[c].dir_dn = 1'b0;
      end
      s_d.ch[c].lim = in_window(pos_n, s_q.ch[c].setup[`LCS_W_LIM_ON], s_q.ch[c].setup[`LCS_W_LIM_OFF]);

      // velocity period; motion watched over its last quarter
      per_len = s_q.ch[c].setup[`LCS_W_CFG][`LCS_CFG_VEL_FAST] ? VEL_FAST_CYC : VEL_SLOW_CYC;
      late_start = per_len - (per_len >> 2);
      if (s_q.ch[c].per_cnt >= per_len - 32'h00000001) begin
        s_d.ch[c].per_cnt = 32'h00000000;
        s_d.ch[c].vzero = !s_q.ch[c].moved;
        s_d.ch[c].moved = 1'b0;
      end else begin
        s_d.ch[c].per_cnt = s_q.ch[c].per_cnt + 32'h00000001;
        if (s_q.ch[c].per_cnt >= late_start && pos_n != s_q.ch[c].pos) begin
          s_d.ch[c].moved = 1'b1;
        end
      end

      // edge capture from the synchronised latch input
      if ((s_q.ch[c].setup[`LCS_W_CFG][`LCS_CFG_RISE_EN] && lat && !s_q.ch[c].lat_prev) ||
          (s_q.ch[c].setup[`LCS_W_CFG][`LCS_CFG_FALL_EN] && !lat && s_q.ch[c].lat_prev)) begin
        s_d.ch[c].cap = pos_n;
      end

      // interpolation: toggle starts it, done finishes it
      s_d.ch[c].int_req = 1'b0;
      if (cmd[`LCS_CMD_INTERP] != s_q.ch[c].cmd_prev[`LCS_CMD_INTERP]) begin
        s_d.ch[c].int_req = 1'b1;
        s_d.ch[c].int_pend = 1'b1;
      end else if (s_q.ch[c].int_pend && interp_done[c]) begin
        s_d.ch[c].int_pend = 1'b0;
        s_d.ch[c].ipos = interp_pos[c];
        s_d.ch[c].ack_int = cmd[`LCS_CMD_INTERP];
        s_d.ch[c].ilim = in_window(interp_pos[c], s_q.ch[c].setup[`LCS_W_LIM_ON],
                                   s_q.ch[c].setup[`LCS_W_LIM_OFF]);
      end

      // fault: a new fault beats the clear in the same cycle
      cfl = cmd_rise[`LCS_CMD_CLR_FLT];
      if (s_q.ch[c].setup[`LCS_W_CFG][`LCS_CFG_FLT_LATCH]) begin
        s_d.ch[c].fault = (s_q.ch[c].fault && !cfl) || flt;
      end else begin
        s_d.ch[c].fault = flt;
      end
    end

    // setup readback; word 7 is the preset offset
    if (rd_req) begin
      s_d.rd_valid = 1'b1;
      if (rd_idx == `LCS_W_OFFSET) begin
        s_d.rd_data = s_q.ch[rd_chan].offset;
      end else if (rd_idx == `LCS_W_CFG) begin
        s_d.rd_data = s_q.ch[rd_chan].setup[0] & `LCS_CFG_VALID_MASK;
      end else begin
        s_d.rd_data = s_q.ch[rd_chan].setup[rd_idx];
      end
    end
  end

  // registers; defaults stand until stored setup is checked
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
      for (int c = 0; c < 2; c++) begin
        s_q.ch[c].setup[0] <= `LCS_DEF_CFG;
        s_q.ch[c].setup[1] <= `LCS_DEF_GRAD;
        s_q.ch[c].setup[2] <= `LCS_DEF_LEN;
        s_q.ch[c].setup[3] <= `LCS_DEF_CNT;
        s_q.ch[c].setup[4] <= `LCS_DEF_ZERO;
        s_q.ch[c].setup[5] <= `LCS_DEF_ZERO;
        s_q.ch[c].setup[6] <= `LCS_DEF_ZERO;
      end
    end else begin
      s_q <= s_d;
    end
  end

  // outputs are flop fields; reserved status bits tied low
  assign wr_done = s_q.wr_done;
  assign wr_err = s_q.wr_err;
  assign wr_code = s_q.wr_code;
  assign rd_valid = s_q.rd_valid;
  assign rd_data = s_q.rd_data;

  for (genvar c = 0; c < 2; c++) begin : g_img
    assign interp_req[c] = s_q.ch[c].int_req;
    assign active_setup[c] = s_q.ch[c].setup;
    assign image[5*c] = {16'h0000, s_q.ch[c].crc_bad, s_q.ch[c].cmd_bad, 6'h00,
                         s_q.ch[c].fault, s_q.ch[c].ilim, s_q.ch[c].lim, s_q.ch[c].lat_s[1],
                         s_q.ch[c].dir_dn, s_q.ch[c].vzero, s_q.ch[c].ack_int, s_q.ch[c].ack_pre};
    assign image[5*c+1] = s_q.ch[c].pos;
    assign image[5*c+2] = s_q.ch[c].vel;
    assign image[5*c+3] = s_q.ch[c].cap;
    assign image[5*c+4] = s_q.ch[c].ipos;
  end

endmodule : lcs_setup_status
`default_nettype wire

// ### design/lcs_consts.svh
`ifndef LCS_CONSTS_SVH
`define LCS_CONSTS_SVH
// setup block word indices; word 7 is readback only
`define LCS_W_CFG 3'h0
`define LCS_W_GRAD 3'h1
`define LCS_W_LEN 3'h2
`define LCS_W_CNT 3'h3
`define LCS_W_PRESET 3'h4
`define LCS_W_LIM_ON 3'h5
`define LCS_W_LIM_OFF 3'h6
`define LCS_W_OFFSET 3'h7
`define LCS_SETUP_WORDS 7
`define LCS_SETUP_BYTES 28
// factory defaults
`define LCS_DEF_CFG 32'h00000000
`define LCS_DEF_GRAD 32'h00015f90
`define LCS_DEF_LEN 32'h00000010
`define LCS_DEF_CNT 32'h00003e80
`define LCS_DEF_ZERO 32'h00000000
// configuration word fields
`define LCS_CFG_FLT_LATCH 8
`define LCS_CFG_DIR_NEG 9
`define LCS_CFG_VEL_FAST 10
`define LCS_CFG_RISE_EN 11
`define LCS_CFG_FALL_EN 12
`define LCS_CFG_MM 13
`define LCS_CFG_MODE_LO 14
`define LCS_CFG_VALID_MASK 32'h0001ff00
`define LCS_MODE_MAX 3'h3
// acceptance ranges
`define LCS_GRAD_MIN 32'h00013880
`define LCS_GRAD_MAX 32'h0001869f
`define LCS_LEN_IN_MIN 32'h00000002
`define LCS_LEN_IN_MAX 32'h00000320
`define LCS_LEN_MM_MIN 32'h00000032
`define LCS_LEN_MM_MAX 32'h00004f60
`define LCS_CNT_MIN 32'h00000002
`define LCS_CNT_IN_MUL 10'h3e8
`define LCS_CNT_MM_MUL 10'h00a
// rejection codes
`define LCS_ERR_NONE 8'h00
`define LCS_ERR_CFG 8'h01
`define LCS_ERR_GRAD 8'h02
`define LCS_ERR_LEN 8'h03
`define LCS_ERR_CNT 8'h04
`define LCS_ERR_CH2 8'h0a
// status word bits
`define LCS_ST_ACK_PRE 0
`define LCS_ST_ACK_INT 1
`define LCS_ST_VZERO 2
`define LCS_ST_DIR_DN 3
`define LCS_ST_LATCH_IN 4
`define LCS_ST_LIM 5
`define LCS_ST_ILIM 6
`define LCS_ST_FAULT 7
`define LCS_ST_CMD_BAD 14
`define LCS_ST_CRC_BAD 15
// command word bits
`define LCS_CMD_PRESET 0
`define LCS_CMD_INTERP 1
`define LCS_CMD_CLR_FLT 2
// velocity update periods
`define LCS_CLK_KHZ 125000
`define LCS_VEL_SLOW_MS 160
`define LCS_VEL_FAST_MS 60
`endif

// ### design/lcs_pkg.sv
`default_nettype none
package lcs_pkg;
  typedef logic [31:0] lcs_word_t;
  typedef lcs_word_t [6:0] lcs_setup_t;

  // per-channel state
  typedef struct packed {
    lcs_setup_t setup;
    lcs_word_t offset;
    lcs_word_t pos;
    lcs_word_t vel;
    lcs_word_t cap;
    lcs_word_t ipos;
    logic ack_pre;
    logic ack_int;
    logic vzero;
    logic dir_dn;
    logic lim;
    logic ilim;
    logic fault;
    logic cmd_bad;
    logic crc_bad;
    logic [1:0] lat_s;
    logic lat_prev;
    logic [1:0] flt_s;
    logic [2:0] cmd_prev;
    logic int_pend;
    logic int_req;
    logic [31:0] per_cnt;
    logic moved;
  } lcs_chan_t;

  typedef struct packed {
    lcs_chan_t [1:0] ch;
    logic booted;
    logic wr_done;
    logic wr_err;
    logic [7:0] wr_code;
    logic rd_valid;
    lcs_word_t rd_data;
  } lcs_state_t;
endpackage : lcs_pkg
`default_nettype wire

// ### test/lcs_host_model.sv
`default_nettype none
// host side: command words plus a slow interpolation responder
module lcs_host_model
  import lcs_pkg::*;
#(
  parameter lcs_word_t IPOS = 32'h00000100
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // bench requests
  input wire logic [1:0][2:0] req_bits,
  input wire logic [1:0] bad_req,
  // toward the device
  output lcs_word_t [1:0] cmd_word,
  input wire logic [1:0] interp_req,
  output logic [1:0] interp_done,
  output lcs_word_t [1:0] interp_pos
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0][2:0] dly_q;
  // spare command bits stay zero unless a fault is asked for
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      cmd_word[i] = {28'h0, bad_req[i], req_bits[i]};
      interp_done[i] = dly_q[i][2];
      // stale data is inverted so a late sample cannot match
      interp_pos[i] = interp_done[i] ? IPOS : ~IPOS;
    end
  end
  // answer three cycles after the request
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      dly_q <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        dly_q[i] <= {dly_q[i][1:0], interp_req[i]};
      end
    end
  end
endmodule : lcs_host_model
`default_nettype wire

// ### test/lcs_setup_status_chk.sv
`default_nettype none
module lcs_setup_status_chk
  import lcs_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // ports watched
  input wire logic two_chan,
  input wire logic wr_valid,
  input wire logic wr_chan,
  input wire lcs_setup_t wr_block,
  input wire logic wr_done,
  input wire logic wr_err,
  input wire logic [7:0] wr_code,
  input wire logic rd_req,
  input wire logic [2:0] rd_idx,
  input wire logic rd_valid,
  input wire lcs_word_t rd_data,
  input wire lcs_word_t [1:0] cmd_word,
  input wire logic [1:0] interp_req,
  input wire lcs_setup_t [1:0] active_setup,
  input wire logic [1:0] latch_pin,
  input wire lcs_word_t [9:0] image
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  AST_WR_DONE: assert property (wr_valid |=> wr_done)
    else $error("write not answered");
  AST_RD_VALID: assert property (rd_req |=> rd_valid)
    else $error("read not answered");
  AST_CFG_RB: assert property (rd_req && rd_idx == 3'h0 |=> (rd_data & ~32'h0001ff00) == 32'h0)
    else $error("reserved config bits read nonzero");
  AST_BAD_KEEP: assert property (wr_valid && (wr_block[0] & ~32'h0001ff00) != 32'h0 |=> wr_err && active_setup == $past(active_setup))
    else $error("bad block stored");
  AST_CH2_SINGLE: assert property (wr_valid && wr_chan && !two_chan |=> wr_code == 8'h0a)
    else $error("second channel write not refused");
  AST_ACK_PRE: assert property (1'b1 |=> image[0][0] == $past(cmd_word[0][0]))
    else $error("preset ack does not follow command");
  AST_CMD_BAD: assert property (|cmd_word[1][31:3] |=> image[5][14])
    else $error("bad command bits not flagged");
  AST_RSVD: assert property (image[0][13:8] == 6'h0 && image[5][31:16] == 16'h0)
    else $error("reserved status bits set");
  AST_INTERP: assert property ($changed(cmd_word[0][1]) |=> interp_req[0])
    else $error("interpolation not started");
  AST_LATCH: assert property ($rose(latch_pin[0]) ##1 latch_pin[0] [*2] |=> image[0][4])
    else $error("latch input not shown");
  COV_REJECT: cover property (wr_done && wr_err);
  COV_INTERP: cover property (interp_req[0]);
  COV_LATCH: cover property (image[0][4]);
endmodule : lcs_setup_status_chk
bind lcs_setup_status lcs_setup_status_chk u_chk (.clock, .resetn, .two_chan, .wr_valid, .wr_chan, .wr_block,
  .wr_done, .wr_err, .wr_code, .rd_req, .rd_idx, .rd_valid, .rd_data, .cmd_word, .interp_req, .active_setup,
  .latch_pin, .image);
`default_nettype wire

// ### test/lcs_setup_status_tb_top.sv
`default_nettype none
module lcs_setup_status_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import lcs_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic two_chan = 1'b1;
  logic wr_valid = 1'b0;
  logic wr_chan = 1'b0;
  logic rd_req = 1'b0;
  logic rd_chan = 1'b0;
  logic [2:0] rd_idx = 3'h0;
  lcs_setup_t wr_block = '0;
  logic [1:0][2:0] req_bits = '0;
  logic [1:0] bad_req = 2'h0;
  logic [1:0] latch_pin = 2'h0;
  logic [1:0] fault_pin = 2'h0;
  logic [1:0] nv_present = 2'h0;
  logic [1:0] nv_crc_ok = 2'h0;
  lcs_setup_t [1:0] nv_block = '0;
  lcs_setup_t [1:0] active_setup;
  lcs_word_t [1:0] raw_pos = '0;
  lcs_word_t [1:0] raw_vel = '0;
  logic wr_done, wr_err, rd_valid;
  logic [7:0] wr_code;
  lcs_word_t rd_data;
  lcs_word_t [1:0] cmd_word, interp_pos;
  logic [1:0] interp_done, interp_req;
  lcs_word_t [9:0] image;
  int unsigned mset[2][7];
  int unsigned moff[2];
  int n_mismatch = 0;
  int compares = 0;
  always #4 clock = ~clock;
  // short velocity periods keep the run small
  lcs_setup_status #(.VEL_SLOW_CYC(40), .VEL_FAST_CYC(16)) dut (.clock, .resetn, .two_chan, .wr_valid, .wr_chan,
    .wr_block, .wr_done, .wr_err, .wr_code, .rd_req, .rd_chan, .rd_idx, .rd_valid, .rd_data, .nv_present,
    .nv_crc_ok, .nv_block, .cmd_word, .raw_pos, .raw_vel, .interp_done, .interp_pos, .interp_req,
    .active_setup, .latch_pin, .fault_pin, .image);
  lcs_host_model host (.clock, .resetn, .req_bits, .bad_req, .cmd_word, .interp_req, .interp_done, .interp_pos);
  // reference acceptance check, same priority as the device
  function automatic int unsigned exp_code(logic ch, logic two, lcs_setup_t b);
    if (ch && !two) return 10;
    if ((b[0] & ~32'h0001ff00) != 0 || b[0][16:14] > 3) return 1;
    if (b[1] < 80000 || b[1] > 99999) return 2;
    if (b[0][13] ? (b[2] < 50 || b[2] > 20320) : (b[2] < 2 || b[2] > 800)) return 3;
    if (b[3] < 2 || b[3] > (b[0][13] ? 10 : 1000) * b[2]) return 4;
    return 0;
  endfunction : exp_code
  task automatic step(int n = 1);
    repeat (n) @(posedge clock);
    #1;
  endtask : step
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // back-to-back reads with the request held high
  task automatic read_all(logic ch);
    rd_req = 1'b1;
    rd_chan = ch;
    for (int i = 0; i < 8; i++) begin
      rd_idx = i[2:0];
      step();
      chk({31'h0, rd_valid}, 32'h1);
      chk(rd_data, i < 7 ? mset[ch][i] : moff[ch]);
      if (i < 7) chk(active_setup[ch][i], mset[ch][i]);
    end
    // one idle edge so a following request never re-raises rd_req in the same step
    rd_req = 1'b0;
    step();
  endtask : read_all
  task automatic write_blk(logic ch, lcs_setup_t b);
    int unsigned code;
    code = exp_code(ch, two_chan, b);
    wr_valid = 1'b1;
    wr_chan = ch;
    wr_block = b;
    step();
    wr_valid = 1'b0;
    chk({31'h0, wr_done}, 32'h1);
    chk({24'h0, wr_code}, code);
    chk({31'h0, wr_err}, {31'h0, code != 0});
    if (code == 0) begin
      for (int i = 0; i < 7; i++) begin
        mset[ch][i] = b[i];
      end
      moff[ch] = 0;
    end
    read_all(ch);
  endtask : write_blk
  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report
  // watchdog
  initial begin
    repeat (5000) @(posedge clock);
    n_mismatch++;
    final_report();
  end
  initial begin
    lcs_setup_t b;
    void'($urandom(32'h5e8d));
    for (int c = 0; c < 2; c++) begin
      mset[c] = '{0, 90000, 16, 16000, 0, 0, 0};
      moff[c] = 0;
    end
    raw_pos[0] = $urandom;
    raw_vel[0] = $urandom;
    raw_pos[1] = $urandom;
    raw_vel[1] = $urandom;
    step(3);
    resetn = 1'b1;
    read_all(0);
    read_all(1);
    $display("test defaults done");
    // boundary and error blocks, codes from the reference
    for (int k = 0; k < 13; k++) begin
      b = '0;
      // units bit kept at inches so the inch ranges below stay meaningful
      b[0] = {15'h0, 1'b0, 2'($urandom), 1'b0, 4'($urandom), 1'b0, 8'h0};
      b[1] = 90000;
      b[2] = 16;
      b[3] = 16000;
      b[4] = $urandom;
      b[5] = $urandom;
      b[6] = $urandom;
      case (k)
        1: b[0][3] = 1'b1;
        2: b[0][16] = 1'b1;
        3: b[1] = 79999;
        4: b[1] = 100000;
        5: b[2] = 801;
        6: b[0][13] = 1'b1;
        7: b[3] = 16001;
        9: b[1] = 80000;
        10: b = {b[6:4], 32'd203200, 32'd20320, b[1], b[0] | 32'h2000};
        11: b[3] = 1;
        12: b[1] = 99999;
        default: b[3] = 2;
      endcase
      two_chan = k != 8;
      write_blk(k == 8 || k == 9, b);
    end
    two_chan = 1'b1;
    $display("test setup blocks done");
    chk(image[2], raw_vel[0]);
    b = {32'h200, 32'h0, 32'd50, 32'd16000, 32'd16, 32'd90000, 32'h0a00};
    write_blk(0, b);
    req_bits[0][0] = 1'b1;
    step();
    chk({31'h0, image[0][0]}, 32'h1);
    step();
    chk(image[1], 50);
    moff[0] = 50 + raw_pos[0];
    // negative count: raw rising by 5 drops the position by 5
    raw_pos[0] = raw_pos[0] + 32'h5;
    step(2);
    chk(image[1], 45);
    chk({31'h0, image[0][3]}, 32'h1);
    read_all(0);
    chk({31'h0, image[0][5]}, 32'h1);
    req_bits[0] = 3'h2;
    for (int i = 0; i < 20 && image[0][1] !== 1'b1; i++) begin
      step();
    end
    chk(image[4], 32'h100);
    chk({31'h0, image[0][6]}, 32'h1);
    latch_pin[0] = 1'b1;
    step(3);
    chk({31'h0, image[0][4]}, 32'h1);
    step();
    chk(image[3], 45);
    write_blk(0, b);
    $display("test preset interp latch done");
    bad_req[1] = 1'b1;
    step(2);
    chk({31'h0, image[5][14]}, 32'h1);
    bad_req[1] = 1'b0;
    step(2);
    chk(image[5] & 32'hffffff00, 32'h0);
    $display("test command fault done");
    // ch2 latched fault holds until cleared; ch1 self-clearing
    b = {32'h0, 32'h0, 32'h0, 32'd16000, 32'd16, 32'd90000, 32'h0100};
    write_blk(1, b);
    chk(image[6], raw_pos[1]);
    chk(image[7], raw_vel[1]);
    chk(image[8] | image[9], 32'h0);
    fault_pin[1] = 1'b1;
    step(3);
    fault_pin[1] = 1'b0;
    step(4);
    chk({31'h0, image[5][7]}, 32'h1);
    req_bits[1][2] = 1'b1;
    step(2);
    chk({31'h0, image[5][7]}, 32'h0);
    fault_pin[0] = 1'b1;
    step(3);
    chk({31'h0, image[0][7]}, 32'h1);
    fault_pin[0] = 1'b0;
    step(3);
    chk({31'h0, image[0][7]}, 32'h0);
    // second reset: ch1 from stored words, ch2 checksum bad
    req_bits = '0;
    nv_present = 2'h3;
    nv_crc_ok = 2'h1;
    nv_block[0] = b;
    resetn = 1'b0;
    step(3);
    resetn = 1'b1;
    mset[0] = mset[1];
    mset[1] = '{0, 90000, 16, 16000, 0, 0, 0};
    moff = '{0, 0};
    step(); // stored words load at the first edge
    read_all(0);
    read_all(1);
    chk({30'h0, image[5][15], image[0][15]}, 32'h2);
    // still, then moving: velocity zero flag over whole periods
    step(45);
    chk({31'h0, image[0][2]}, 32'h1);
    for (int i = 0; i < 60; i++) begin
      raw_pos[0] = raw_pos[0] + 32'h1;
      step();
    end
    chk({30'h0, image[0][3:2]}, 32'h0);
    $display("test fault and stored setup done");
    final_report();
  end
endmodule : lcs_setup_status_tb_top
`default_nettype wire
